// File: hw/flyback_defs.svh
// Constants of the flyback startup, fault and PWM controller.
// Assumes a 100 MHz system clock; included by its bare name.
// Operation
// - Gate output held low whenever undervoltage lockout is active.
// - Startup charge generator on only while drain start comparator is high.
// - Charge current normal on first start, reduced after a fault.
// - Reaching supply-on starts switching and stops the charge generator.
// - Every start attempt ramps the current limit up over 8.5 ms.
// - Supply below supply-off stops switching.
// - After power down with input below drain start, startup is inhibited.
// - With input present, recharge starts only below supply restart threshold.
// - Nominal switching frequency fixed per variant, 60 kHz or 115 kHz.
// - Frequency jitters 4 kHz or 8 kHz around nominal at 250 Hz.
// - Gate turns off when sensed current reaches the feedback level.
// - Current limit stays default unless the limit pin sinks enough current.
// - Overvoltage pin is evaluated only while the power switch is off.
// - Four consecutive overvoltage samples stop switching and enter auto-restart.
// - Overvoltage sample taken in a short window after the strobe delay.
// - Each high sample counts up; a cycle without one clears the counter.
// - Faults recover through slow auto-restart, never latching.
// - Strobe delay from turn-off to sampling window is 2.2 us.
`ifndef FLYBACK_DEFS_SVH
`define FLYBACK_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and oscillator
// ----------------------------------------------------------------------
`define CLK_KHZ          100000
`define OSC_LO_KHZ       60
`define OSC_HI_KHZ       115
`define JIT_LO_KHZ       4
`define JIT_HI_KHZ       8
`define JIT_MOD_HZ       250
`define OSC_PER(f)       (`CLK_KHZ / (f))
`define OSC_DEV(f, d)    (`CLK_KHZ / ((f) - (d)) - `CLK_KHZ / (f))
`define JIT_DIV(f, d)    ((`CLK_KHZ * 1000) / (`JIT_MOD_HZ * 4 * `OSC_DEV(f, d)))

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SOFTSTART_US     8500
`define SOFTSTART_CYC    (`SOFTSTART_US * (`CLK_KHZ / 1000))
`define OVP_STROBE_NS    2200
`define OVP_STROBE_CYC   ((`OVP_STROBE_NS * (`CLK_KHZ / 1000) + 999) / 1000)
`define OVP_WINDOW_NS    300
`define OVP_WINDOW_CYC   ((`OVP_WINDOW_NS * (`CLK_KHZ / 1000)) / 1000)
`define LEB_NS           300
`define LEB_CYC          ((`LEB_NS * (`CLK_KHZ / 1000) + 999) / 1000)
`define DMAX_PCT         75

// ----------------------------------------------------------------------
// Levels and counts
// ----------------------------------------------------------------------
`define OVP_TRIP_COUNT   3'h4
`define ILIM_MIN         8'h00
`define ILIM_MAX         8'hFF
`define ILIM_STEPS       255

// ----------------------------------------------------------------------
// Synchroniser bit positions
// ----------------------------------------------------------------------
`define SYNC_W           8
`define SY_DRAIN         0
`define SY_SUP_ON        1
`define SY_SUP_OFF       2
`define SY_SUP_RST       3
`define SY_ADJ           4
`define SY_OVP           5
`define SY_PWM           6
`define SY_LIM           7

`endif

// File: hw/flyback_pkg.sv
// Types of the flyback controller: state records and enumerations.
// Assumes flyback_defs.svh for widths.
`default_nettype none
`include "flyback_defs.svh"

package flyback_pkg;

  // Sequencer phases
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CHARGE, SEQ_RUN, SEQ_RESTART} seq_e;

  // Overvoltage sampler phases
  typedef enum logic [1:0] {OVP_IDLE, OVP_DELAY, OVP_WINDOW} ovp_phase_e;

  typedef struct packed {
    seq_e                 seq;
    logic [`SYNC_W-1:0]   s1;
    logic [`SYNC_W-1:0]   s2;
    logic [`SYNC_W-1:0]   s3;
    logic [`SYNC_W-1:0]   flt;
    logic                 gate;
    logic                 hv_en;
    logic                 low_chg;
    logic                 adj;
    logic                 switching;
    logic [7:0]           ilim;
    logic [19:0]          ss_div;
    logic [11:0]          on_cnt;
  } core_s;

  typedef struct packed {
    logic [11:0]          cnt;
    logic [11:0]          div;
    logic signed [8:0]    jit;
    logic                 up;
    logic                 tick;
  } osc_s;

  typedef struct packed {
    ovp_phase_e           phase;
    logic [8:0]           tmr;
    logic                 gate_q;
    logic                 hit;
    logic [2:0]           cnt;
    logic                 trip;
  } ovp_s;

endpackage

`default_nettype wire

// File: hw/ctrl_if.sv
// Interface joining the controller core, oscillator and overvoltage sampler.
// Assumes all three parties run on the one system clock.
`timescale 1ns/1ps
`default_nettype none

interface ctrl_if;
  logic       cycle_start;
  logic       run;
  logic       gate_on;
  logic       ovp_level;
  logic       ovp_trip;
  logic [2:0] ovp_count;

  modport osc  (output cycle_start);
  modport ovp  (input cycle_start, run, gate_on, ovp_level, output ovp_trip, ovp_count);
  modport core (output run, gate_on, ovp_level, input cycle_start, ovp_trip, ovp_count);
endinterface // ctrl_if

`default_nettype wire

// File: hw/jitter_osc.sv
// Switching oscillator with triangular frequency jitter.
// Assumes a 100 MHz clock; emits one-cycle pulses at each cycle start.
`timescale 1ns/1ps
`default_nettype none
`include "flyback_defs.svh"

module jitter_osc #(
  parameter bit HIGH_FREQ = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Cycle start towards core and sampler
  ctrl_if.osc      cif
);

  localparam int F_KHZ = HIGH_FREQ ? `OSC_HI_KHZ : `OSC_LO_KHZ;
  localparam int D_KHZ = HIGH_FREQ ? `JIT_HI_KHZ : `JIT_LO_KHZ;
  localparam logic [11:0]       PER_C = 12'(`OSC_PER(F_KHZ));
  localparam logic signed [8:0] DEV_C = 9'(`OSC_DEV(F_KHZ, D_KHZ));
  localparam logic [11:0]       DIV_C = 12'(`JIT_DIV(F_KHZ, D_KHZ) - 1);

  flyback_pkg::osc_s st_r;
  flyback_pkg::osc_s st_nxt;
  logic [11:0]       limit;

  // Period counter and jitter triangle
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    limit       = PER_C + {{3{st_r.jit[8]}}, st_r.jit} - 12'h001;
    if (st_r.cnt >= limit) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 12'h001;
    end
    if (st_r.div == DIV_C) begin
      st_nxt.div = '0;
      if (st_r.up) begin
        if (st_r.jit == DEV_C) st_nxt.up = 1'b0;
        else st_nxt.jit = st_r.jit + 9'sh001;
      end else begin
        if (st_r.jit == -DEV_C) st_nxt.up = 1'b1;
        else st_nxt.jit = st_r.jit - 9'sh001;
      end
    end else begin
      st_nxt.div = st_r.div + 12'h001;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign cif.cycle_start = st_r.tick;

endmodule // jitter_osc

`default_nettype wire

// File: hw/ovp_sampler.sv
// Overvoltage sampler: strobe delay, sample window and consecutive counter.
// Assumes a synchronised comparator level and the registered gate state.
`timescale 1ns/1ps
`default_nettype none
`include "flyback_defs.svh"

module ovp_sampler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to the core
  ctrl_if.ovp      cif
);

  localparam logic [8:0] STROBE_C = 9'(`OVP_STROBE_CYC - 1);
  localparam logic [8:0] WINDOW_C = 9'(`OVP_WINDOW_CYC - 1);

  flyback_pkg::ovp_s st_r;
  flyback_pkg::ovp_s st_nxt;

  // Sampling sequence and event counter
  always_comb begin
    st_nxt        = st_r;
    st_nxt.trip   = 1'b0;
    st_nxt.gate_q = cif.gate_on;
    if (cif.cycle_start) begin
      st_nxt.hit = 1'b0;
      if (!st_r.hit) st_nxt.cnt = '0;
    end
    unique case (st_r.phase)
      flyback_pkg::OVP_IDLE: begin
        if (st_r.gate_q && !cif.gate_on) begin
          st_nxt.phase = flyback_pkg::OVP_DELAY;
          st_nxt.tmr   = '0;
        end
      end
      flyback_pkg::OVP_DELAY: begin
        if (st_r.tmr == STROBE_C) begin
          st_nxt.phase = flyback_pkg::OVP_WINDOW;
          st_nxt.tmr   = '0;
        end else begin
          st_nxt.tmr = st_r.tmr + 9'h001;
        end
      end
      flyback_pkg::OVP_WINDOW: begin
        if (cif.ovp_level) begin
          st_nxt.phase = flyback_pkg::OVP_IDLE;
          st_nxt.hit   = 1'b1;
          if (st_r.cnt + 3'h1 == `OVP_TRIP_COUNT) begin
            st_nxt.cnt  = '0;
            st_nxt.trip = 1'b1;
          end else begin
            st_nxt.cnt = st_r.cnt + 3'h1;
          end
        end else if (st_r.tmr == WINDOW_C) begin
          st_nxt.phase = flyback_pkg::OVP_IDLE;
        end else begin
          st_nxt.tmr = st_r.tmr + 9'h001;
        end
      end
      default: st_nxt.phase = flyback_pkg::OVP_IDLE;
    endcase
    // Turn-on ends any pending evaluation
    if (cif.gate_on) st_nxt.phase = flyback_pkg::OVP_IDLE;
    if (!cif.run) begin
      st_nxt.phase = flyback_pkg::OVP_IDLE;
      st_nxt.cnt   = '0;
      st_nxt.hit   = 1'b0;
      st_nxt.trip  = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign cif.ovp_trip  = st_r.trip;
  assign cif.ovp_count = st_r.cnt;

endmodule // ovp_sampler

`default_nettype wire

// File: hw/flyback_ctrl.sv
// Top of the flyback controller: input synchronisers, startup sequencer,
// soft-start ramp, cycle-by-cycle PWM and fault auto-restart.
// Assumes comparator flags arrive asynchronously from the analog front end
// and that the gate driver and current limit DAC follow the outputs.
`timescale 1ns/1ps
`default_nettype none
`include "flyback_defs.svh"

module flyback_ctrl #(
  parameter bit HIGH_FREQ        = 1'b0,
  parameter int SOFTSTART_CYCLES = `SOFTSTART_CYC
) (
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RESET,
  // Supply and input comparators
  input  wire logic       DRAIN_START_CMP,
  input  wire logic       SUPPLY_ON_CMP,
  input  wire logic       SUPPLY_OFF_CMP,
  input  wire logic       SUPPLY_RESTART_CMP,
  // Limit and overvoltage pin comparators
  input  wire logic       LIMIT_ADJ_CMP,
  input  wire logic       OVP_CMP,
  // Current sense comparators
  input  wire logic       PWM_CMP,
  input  wire logic       ILIM_CMP,
  // Power switch and startup generator
  output logic            GATE_DRIVE,
  output logic            HV_STARTUP_EN,
  output logic            CHARGE_LOW_SEL,
  // Current limit setting
  output logic [7:0]      ILIM_LEVEL,
  output logic            ILIM_ADJUST,
  // Status
  output logic            SWITCHING,
  output logic [2:0]      OVP_COUNT
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam int F_KHZ = HIGH_FREQ ? `OSC_HI_KHZ : `OSC_LO_KHZ;
  localparam logic [19:0] SS_STEP_C = 20'(SOFTSTART_CYCLES / `ILIM_STEPS - 1);
  localparam logic [11:0] LEB_C     = 12'(`LEB_CYC);
  localparam logic [11:0] DMAX_C    = 12'(`OSC_PER(F_KHZ) * `DMAX_PCT / 100);

  // ----------------------------------------------------------------------
  // State and links
  // ----------------------------------------------------------------------
  flyback_pkg::core_s st_r;
  flyback_pkg::core_s st_nxt;
  logic [`SYNC_W-1:0] raw;
  logic               drain_ok;
  logic               sup_on;
  logic               sup_off;
  logic               sup_rst;
  logic               pwm_hit;
  logic               lim_hit;
  logic               blanked;

  ctrl_if cif ();

  // Oscillator instance
  jitter_osc #(
    .HIGH_FREQ (HIGH_FREQ)
  ) u_osc (
    .clk (SYS_CLK),
    .rst (RESET),
    .cif (cif)
  );

  // Overvoltage sampler instance
  ovp_sampler u_ovp (
    .clk (SYS_CLK),
    .rst (RESET),
    .cif (cif)
  );

  // Raw comparator vector
  always_comb begin
    raw                = '0;
    raw[`SY_DRAIN]     = DRAIN_START_CMP;
    raw[`SY_SUP_ON]    = SUPPLY_ON_CMP;
    raw[`SY_SUP_OFF]   = SUPPLY_OFF_CMP;
    raw[`SY_SUP_RST]   = SUPPLY_RESTART_CMP;
    raw[`SY_ADJ]       = LIMIT_ADJ_CMP;
    raw[`SY_OVP]       = OVP_CMP;
    raw[`SY_PWM]       = PWM_CMP;
    raw[`SY_LIM]       = ILIM_CMP;
  end

  // Filtered flags used by the sequencer and, after leading-edge blanking, by the PWM
  assign drain_ok = st_r.flt[`SY_DRAIN];
  assign sup_on   = st_r.flt[`SY_SUP_ON];
  assign sup_off  = st_r.flt[`SY_SUP_OFF];
  assign sup_rst  = st_r.flt[`SY_SUP_RST];
  assign blanked  = (st_r.on_cnt < LEB_C);
  assign pwm_hit  = st_r.flt[`SY_PWM] && !blanked;
  assign lim_hit  = st_r.flt[`SY_LIM] && !blanked;

  // Links to the overvoltage sampler
  assign cif.run       = st_r.switching;
  assign cif.gate_on   = st_r.gate;
  assign cif.ovp_level = st_r.flt[`SY_OVP];

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Synchronisers, sequencer, ramp and PWM
  always_comb begin
    st_nxt = st_r;

    // Three-stage capture, a change counts when stages two and three agree
    st_nxt.s1  = raw;
    st_nxt.s2  = st_r.s1;
    st_nxt.s3  = st_r.s2;
    st_nxt.flt = (st_r.s2 & st_r.s3) | (st_r.flt & (st_r.s2 | st_r.s3));

    // Limit adjust follows the pin sink detection
    st_nxt.adj = st_r.flt[`SY_ADJ];

    unique case (st_r.seq)
      // Waiting for the bulk voltage to appear
      flyback_pkg::SEQ_IDLE: begin
        st_nxt.hv_en     = 1'b0;
        st_nxt.switching = 1'b0;
        if (drain_ok) begin
          st_nxt.seq     = flyback_pkg::SEQ_CHARGE;
          st_nxt.low_chg = 1'b0;
        end
      end

      // Startup generator charges the supply capacitor
      flyback_pkg::SEQ_CHARGE: begin
        st_nxt.hv_en     = drain_ok;
        st_nxt.switching = 1'b0;
        if (sup_on) begin
          st_nxt.seq       = flyback_pkg::SEQ_RUN;
          st_nxt.hv_en     = 1'b0;
          st_nxt.switching = 1'b1;
          st_nxt.ilim      = `ILIM_MIN;
          st_nxt.ss_div    = '0;
        end
      end

      // Switching with soft-start ramp
      flyback_pkg::SEQ_RUN: begin
        st_nxt.hv_en = 1'b0;
        if (st_r.ilim != `ILIM_MAX) begin
          if (st_r.ss_div == SS_STEP_C) begin
            st_nxt.ss_div = '0;
            st_nxt.ilim   = st_r.ilim + 8'h01;
          end else begin
            st_nxt.ss_div = st_r.ss_div + 20'h00001;
          end
        end
        if (cif.ovp_trip) begin
          st_nxt.seq       = flyback_pkg::SEQ_RESTART;
          st_nxt.switching = 1'b0;
          st_nxt.low_chg   = 1'b1;
        end else if (sup_off) begin
          st_nxt.switching = 1'b0;
          if (drain_ok) begin
            st_nxt.seq     = flyback_pkg::SEQ_RESTART;
            st_nxt.low_chg = 1'b1;
          end else begin
            st_nxt.seq     = flyback_pkg::SEQ_IDLE;
            st_nxt.low_chg = 1'b0;
          end
        end
      end

      // Supply decays until the restart threshold
      flyback_pkg::SEQ_RESTART: begin
        st_nxt.hv_en     = 1'b0;
        st_nxt.switching = 1'b0;
        if (!drain_ok) begin
          st_nxt.seq     = flyback_pkg::SEQ_IDLE;
          st_nxt.low_chg = 1'b0;
        end else if (sup_rst) begin
          st_nxt.seq   = flyback_pkg::SEQ_CHARGE;
          st_nxt.hv_en = 1'b1;
        end
      end

      default: begin
        st_nxt.seq       = flyback_pkg::SEQ_IDLE;
        st_nxt.hv_en     = 1'b0;
        st_nxt.switching = 1'b0;
      end
    endcase

    // Cycle-by-cycle PWM: on at cycle start, off on current or duty limit
    if (st_r.gate) begin
      if (st_r.on_cnt != 12'hFFF) st_nxt.on_cnt = st_r.on_cnt + 12'h001;
      if (pwm_hit || lim_hit || st_r.on_cnt >= DMAX_C) begin
        st_nxt.gate = 1'b0;
      end
    end
    if (cif.cycle_start && st_r.switching && st_nxt.switching) begin
      st_nxt.gate   = 1'b1;
      st_nxt.on_cnt = '0;
    end

    // Lockout: no switching means the gate is held low
    if (!st_nxt.switching) begin
      st_nxt.gate   = 1'b0;
      st_nxt.on_cnt = '0;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Synchronous reset to lockout
  always_ff @(posedge SYS_CLK) begin
    if (RESET) st_r <= '0;
    else st_r <= st_nxt;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // All outputs straight from flip-flops
  assign GATE_DRIVE     = st_r.gate;
  assign HV_STARTUP_EN  = st_r.hv_en;
  assign CHARGE_LOW_SEL = st_r.low_chg;
  assign ILIM_LEVEL     = st_r.ilim;
  assign ILIM_ADJUST    = st_r.adj;
  assign SWITCHING      = st_r.switching;
  assign OVP_COUNT      = cif.ovp_count;

endmodule // flyback_ctrl

`default_nettype wire

// File: tb/flyback_ctrl_properties.sv
// Port checker of the flyback controller, bound onto its top module.
// Assumes one clock SYS_CLK and the synchronous active-high RESET.
`timescale 1ns/1ps
`default_nettype none

module flyback_ctrl_properties #(
  parameter int SOFTSTART_CYCLES = 2550
) (
  // Clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RESET,
  // Watched ports
  input wire logic       DRAIN_START_CMP,
  input wire logic       GATE_DRIVE,
  input wire logic       HV_STARTUP_EN,
  input wire logic [7:0] ILIM_LEVEL,
  input wire logic       SWITCHING,
  input wire logic [2:0] OVP_COUNT
);
  localparam int STEP = SOFTSTART_CYCLES / 255;
  logic [11:0] stay_r;
  logic [11:0] off_r;
  logic [7:0]  ilim_q;

  // Cycles at one limit code, cycles with the gate off
  always_ff @(posedge SYS_CLK) begin
    stay_r <= (RESET || !SWITCHING || ILIM_LEVEL != ilim_q) ? 12'h000 : stay_r + 12'h001;
    off_r  <= (RESET || GATE_DRIVE) ? 12'h000 : off_r + {11'h000, off_r != 12'hFFF};
    ilim_q <= ILIM_LEVEL;
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  a_gate_needs_run: assert property (GATE_DRIVE |-> SWITCHING)
    else $error("gate on outside run state");
  a_hv_off_run: assert property (SWITCHING |-> !HV_STARTUP_EN)
    else $error("startup generator on while switching");
  a_hv_no_drain: assert property (!DRAIN_START_CMP [*8] |-> !HV_STARTUP_EN)
    else $error("startup generator on without input");
  a_ss_from_zero: assert property ($rose(SWITCHING) |-> ILIM_LEVEL == 8'h00)
    else $error("soft-start not from minimum");
  a_ss_monotonic: assert property ($past(SWITCHING) && SWITCHING |->
    ILIM_LEVEL - $past(ILIM_LEVEL) <= 8'h01)
    else $error("limit step not single and upward");
  a_ss_rate: assert property (SWITCHING && ILIM_LEVEL != 8'hFF |-> stay_r <= STEP + 2)
    else $error("limit ramp stalled");
  a_ovp_idle_zero: assert property (!SWITCHING && !$past(SWITCHING) |-> OVP_COUNT == 3'h0)
    else $error("overvoltage count kept while stopped");
  a_ovp_after_strobe: assert property (OVP_COUNT > $past(OVP_COUNT) |-> off_r >= 12'h0DC)
    else $error("overvoltage sample too early or gate on");
  a_ovp_below_four: assert property (OVP_COUNT <= 3'h3)
    else $error("overvoltage count passed trip level");

  // Main scenarios
  cover property ($rose(SWITCHING));
  cover property (ILIM_LEVEL == 8'hFF);
  cover property (OVP_COUNT == 3'h3);
endmodule // flyback_ctrl_properties

bind flyback_ctrl flyback_ctrl_properties #(.SOFTSTART_CYCLES(SOFTSTART_CYCLES))
  flyback_ctrl_properties_inst (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .DRAIN_START_CMP(DRAIN_START_CMP), .GATE_DRIVE(GATE_DRIVE), .HV_STARTUP_EN(HV_STARTUP_EN),
  .ILIM_LEVEL(ILIM_LEVEL), .SWITCHING(SWITCHING), .OVP_COUNT(OVP_COUNT));

`default_nettype wire

// File: tb/power_stage_model.sv
// Behavioural flyback stage: drain current ramp and auxiliary winding flags.
// Assumes the gate drive and clock of the controller under test.
`timescale 1ns/1ps
`default_nettype none

module power_stage_model (
  // Clock and gate
  input  wire logic        clk,
  input  wire logic        gate,
  // Scenario controls
  input  wire logic [11:0] ramp_len,
  input  wire logic        fb_open,
  input  wire logic        ovp_mode,
  input  wire logic        ovp_early,
  // Comparator flags
  output logic             pwm_cmp,
  output logic             ilim_cmp,
  output logic             ovp_cmp
);
  logic [11:0] on_r  = 12'h000;
  logic [11:0] off_r = 12'h000;
  logic [2:0]  flg_r = 3'h0;

  // Current rises while on; the winding shows output only while off
  always_ff @(posedge clk) begin
    on_r  <= gate ? on_r + 12'h001 : 12'h000;
    off_r <= gate ? 12'h000 : off_r + {11'h000, off_r != 12'hFFF};
    flg_r <= {gate && !fb_open && on_r >= ramp_len,
              gate && on_r >= ramp_len + 12'h014,
              ovp_mode && !gate && (!ovp_early || off_r < 12'h064)};
  end
  assign {pwm_cmp, ilim_cmp, ovp_cmp} = flg_r;
endmodule // power_stage_model

`default_nettype wire

// File: tb/flyback_ctrl_tb.sv
// Self-checking bench of the flyback controller with a power stage model.
// Assumes a shortened soft-start count and the 60 kHz variant.
`timescale 1ns/1ps
`default_nettype none

module flyback_ctrl_tb;
  localparam int SS = 2550;
  localparam int R  = 400;
  logic        sys_clk, rst, drain, sup_on, sup_off, sup_rst, adj;
  logic        fb_open, ovp_mode, ovp_early, pwm, ilim_c, ovp, g_q;
  logic        gate, hv_en, low_sel, adj_out, sw;
  logic [7:0]  ilim;
  logic [2:0]  ovp_cnt;
  logic [8:0]  rows [10];
  int          fails, tests_run, n, k, ton, per, p0, p1;

  flyback_ctrl #(.HIGH_FREQ(1'b0), .SOFTSTART_CYCLES(SS)) flyback_ctrl_inst (
    .SYS_CLK(sys_clk), .RESET(rst), .DRAIN_START_CMP(drain), .SUPPLY_ON_CMP(sup_on),
    .SUPPLY_OFF_CMP(sup_off), .SUPPLY_RESTART_CMP(sup_rst), .LIMIT_ADJ_CMP(adj),
    .OVP_CMP(ovp), .PWM_CMP(pwm), .ILIM_CMP(ilim_c), .GATE_DRIVE(gate),
    .HV_STARTUP_EN(hv_en), .CHARGE_LOW_SEL(low_sel), .ILIM_LEVEL(ilim),
    .ILIM_ADJUST(adj_out), .SWITCHING(sw), .OVP_COUNT(ovp_cnt));
  power_stage_model power_stage_model_inst (.clk(sys_clk), .gate(gate),
    .ramp_len(12'(R)), .fb_open(fb_open), .ovp_mode(ovp_mode), .ovp_early(ovp_early),
    .pwm_cmp(pwm), .ilim_cmp(ilim_c), .ovp_cmp(ovp));

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  // Bounded wait for a gate level, counting cycles
  task automatic wait_gate(input logic lvl, output int c);
    c = 0;
    while (gate !== lvl) begin
      tick(1);
      c++;
      if (c > 4000) begin
        fails++;
        final_report();
      end
    end
  endtask

  task automatic period_of(output int t_on, output int t_per);
    int t_off;
    wait_gate(1'b1, t_off);
    wait_gate(1'b0, t_on);
    wait_gate(1'b1, t_off);
    t_per = t_on + t_off;
  endtask

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Rows: drain, on, off, restart, adjust | switching, hv, low, adjust out
  initial begin
    rows = '{9'h000, 9'h104, 9'h115, 9'h199, 9'h142, 9'h126, 9'h18A, 9'h040, 9'h020, 9'h104};
    fails = 0;
    tests_run = 0;
    rst = 1'b1;
    {drain, sup_on, sup_off, sup_rst, adj} = 5'h00;
    {fb_open, ovp_mode, ovp_early} = 3'h0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk) {drain, sup_on, sup_off, sup_rst, adj} <= rows[i][8:4];
      tick(12);
      check_val({12'h000, sw, hv_en, low_sel, adj_out}, {12'h000, rows[i][3:0]});
    end
    $display("test sequencer rows done");
    @(posedge sys_clk) sup_on <= 1'b1;
    n = 0;
    while (ilim !== 8'hFF && n < 4000) begin
      tick(1);
      n++;
    end
    if (n >= 4000) begin
      fails++;
      final_report();
    end
    check_val(16'(n >= SS - 5 && n <= SS + 20), 16'h0001);
    period_of(ton, p0);
    check_val(16'(p0 >= 1545 && p0 <= 1787), 16'h0001);
    check_val(16'(ton >= R + 2 && ton <= R + 12), 16'h0001);
    repeat (19) period_of(ton, per);
    period_of(ton, p1);
    n = (p0 > p1) ? p0 - p1 : p1 - p0;
    check_val(16'(n >= 30 && n <= 50), 16'h0001);
    @(posedge sys_clk) fb_open <= 1'b1;
    period_of(ton, per);
    check_val(16'(ton >= R + 22 && ton <= R + 32), 16'h0001);
    $display("test soft-start and pwm done");
    @(posedge sys_clk) {fb_open, ovp_mode} <= 2'h1;
    wait_gate(1'b0, n);
    tick(300);
    check_val({13'h0000, ovp_cnt}, 16'h0001);
    wait_gate(1'b1, n);
    wait_gate(1'b0, n);
    tick(300);
    check_val({13'h0000, ovp_cnt}, 16'h0002);
    @(posedge sys_clk) ovp_mode <= 1'b0;
    wait_gate(1'b1, n);
    wait_gate(1'b0, n);
    wait_gate(1'b1, n);
    tick(2);
    check_val({12'h000, sw, ovp_cnt}, 16'h0008);
    @(posedge sys_clk) {ovp_mode, ovp_early} <= 2'h3;
    repeat (5) period_of(ton, per);
    check_val({12'h000, sw, ovp_cnt}, 16'h0008);
    @(posedge sys_clk) ovp_early <= 1'b0;
    k = 0;
    n = 0;
    g_q = gate;
    while (sw === 1'b1 && n < 9000) begin
      tick(1);
      n++;
      k += (g_q && !gate) ? 1 : 0;
      g_q = gate;
    end
    if (n >= 9000) begin
      fails++;
      final_report();
    end
    check_val({12'(k), sw, hv_en, low_sel, gate}, {12'h004, 4'h2});
    @(posedge sys_clk) {ovp_mode, sup_on, sup_rst} <= 3'h1;
    tick(12);
    check_val({13'h0000, sw, hv_en, low_sel}, 16'h0003);
    @(posedge sys_clk) {sup_on, sup_rst} <= 2'h2;
    tick(12);
    check_val({15'h0000, sw && ilim <= 8'h01}, 16'h0001);
    $display("test overvoltage and restart done");
    @(posedge sys_clk) rst <= 1'b1;
    tick(3);
    check_val({gate, hv_en, low_sel, ilim, adj_out, sw, ovp_cnt}, 16'h0000);
    @(posedge sys_clk) rst <= 1'b0;
    tick(2);
    check_val({13'h0000, gate, hv_en, sw}, 16'h0000);
    $display("test reset done");
    final_report();
  end
endmodule // flyback_ctrl_tb

`default_nettype wire
